// >>> hdl/dcwc_codec.v
// Functional notes
// (RL1) Status word 16 bits, zeros at 6,13,14
// (RL2) Bit0 forward, bit1 reverse rotation
// (RL3) Bit2 DC braking, bit3 output shut down
// (RL4) Bit4 braking, zero on small variant
// (RL5) Bit5 one when DC link established
// (RL6) Bits 7-10 vlimit, ilimit, accel, decel
// (RL7) Bit11 alarm, bit12 comm, bit15 writing
// (RL8) Model word: four nibble fields
// (RL9) Current step 0.01A or 0.1A
// (RL10) Small drive rejects current above 655A
// (RL11) Keep four digits, truncate the rest
// (RL12) Codes 71-73, no response sent
// (RL13) Proprietary codes 74 to 81 in order
// (RL14) RTU codes 1, 2, 3
// (RL15) RTU code 7 for refusal
// (RL16) Tuning: bit8 fwd, bit9 rev, low data
// (RL17) Ignore tuning with both directions set
// (RL18) Tuning readback direction bits zero
// (RL19) Frequency unsigned, 0.01Hz units
// (RL20) Sign char minus reverse, space forward
// (RL21) Send upper byte then lower byte
// (RL22) Status sampled in one cycle
`timescale 1ns/1ps
`include "dcwc_defs.vh"

module dcwc_codec #(
  parameter SMALL_VARIANT = 1'b0,
  parameter [3:0] MODEL_TYPE  = 4'h1,
  parameter [3:0] MODEL_GEN   = 4'h1,
  parameter [3:0] MODEL_DEST  = 4'h1,
  parameter [3:0] MODEL_POWER = 4'h1
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        ce,
  input  wire        turning_forward,
  input  wire        turning_reverse,
  input  wire        dc_braking_active,
  input  wire        output_shut_down,
  input  wire        braking_active,
  input  wire        dc_link_voltage_ok,
  input  wire        voltage_limiting,
  input  wire        current_limiting,
  input  wire        accelerating,
  input  wire        decelerating,
  input  wire        fault_alarm_relay,
  input  wire        comm_control_effective,
  input  wire        fcode_writing,
  input  wire        status_sample,
  input  wire        large_drive,
  input  wire [15:0] cur_wr_data,
  input  wire        cur_wr,
  input  wire        err_valid,
  input  wire [3:0]  err_src,
  input  wire        rtu_mode,
  input  wire [15:0] tune_wr_data,
  input  wire        tune_wr,
  input  wire [15:0] freq_in,
  input  wire        freq_reverse,
  input  wire [15:0] tx_word,
  input  wire        tx_start,
  output reg  [15:0] status_word,
  output reg  [15:0] model_word,
  output reg  [15:0] cur_value,
  output reg         cur_rejected,
  output reg  [15:0] err_code,
  output reg         err_no_response,
  output reg  [7:0]  tune_value,
  output reg         tune_cmd_fwd,
  output reg         tune_cmd_rev,
  output reg         tune_cmd_pulse,
  output reg  [15:0] tune_readback,
  output reg  [15:0] freq_word,
  output reg  [7:0]  freq_sign_char,
  output reg  [7:0]  tx_byte,
  output reg         tx_byte_valid
);

  // Truncate to four significant decimal digits; the drop factor is a power of ten
  function [15:0] trunc4;
    input [15:0] v;
    begin
      if (v >= `DCWC_CUR_KEEP)
        trunc4 = (v / `DCWC_CUR_DIGIT) * `DCWC_CUR_DIGIT; // RL11
      else
        trunc4 = v;
    end
  endfunction

  // Proprietary codes run in source order from the format error upward
  function [15:0] prop_code;
    input [3:0] src;
    begin
      prop_code = `DCWC_CODE_PROP0 + {12'h000, src - `DCWC_ERR_FORMAT}; // RL13
    end
  endfunction

  reg        tx_second;
  reg [7:0]  tx_low;
  wire [15:0] next_status;

  assign next_status = {fcode_writing, 2'b00, comm_control_effective, // RL7 RL1
                        fault_alarm_relay, decelerating, accelerating,
                        current_limiting, voltage_limiting, 1'b0,     // RL6 RL1
                        dc_link_voltage_ok,                           // RL5
                        braking_active & ~SMALL_VARIANT,              // RL4
                        output_shut_down, dc_braking_active,          // RL3
                        turning_reverse, turning_forward};            // RL2

  always @(posedge clk_sys) begin
    if (!rstn) begin
      status_word     <= 16'h0000;
      model_word      <= 16'h0000;
      cur_value       <= 16'h0000;
      cur_rejected    <= 1'b0;
      err_code        <= 16'h0000;
      err_no_response <= 1'b0;
      tune_value      <= 8'h00;
      tune_cmd_fwd    <= 1'b0;
      tune_cmd_rev    <= 1'b0;
      tune_cmd_pulse  <= 1'b0;
      tune_readback   <= 16'h0000;
      freq_word       <= 16'h0000;
      freq_sign_char  <= `DCWC_ASCII_SPACE;
      tx_byte         <= 8'h00;
      tx_byte_valid   <= 1'b0;
      tx_second       <= 1'b0;
      tx_low          <= 8'h00;
    end else if (ce) begin
      model_word <= {MODEL_TYPE, MODEL_GEN, MODEL_DEST, MODEL_POWER}; // RL8
      if (status_sample)
        status_word <= next_status; // RL22
      cur_rejected <= 1'b0;
      if (cur_wr) begin
        // Large drives use 0.1 A steps, so 16 bits never exceed the limit
        if (!large_drive && cur_wr_data > `DCWC_CUR_MAX)
          cur_rejected <= 1'b1; // RL10 RL9
        else
          cur_value <= trunc4(cur_wr_data); // RL11
      end
      if (err_valid) begin
        err_no_response <= 1'b0;
        case (err_src)
          `DCWC_ERR_CRC: begin
            err_code        <= `DCWC_CODE_CRC; // RL12
            err_no_response <= 1'b1;
          end
          `DCWC_ERR_PARITY: begin
            err_code        <= `DCWC_CODE_PARITY; // RL12
            err_no_response <= 1'b1;
          end
          `DCWC_ERR_FRAME: begin
            err_code        <= `DCWC_CODE_FRAME; // RL12
            err_no_response <= 1'b1;
          end
          `DCWC_ERR_FORMAT, `DCWC_ERR_CMD, `DCWC_ERR_DATA, `DCWC_ERR_BUSY: begin
            if (rtu_mode)
              err_code <= `DCWC_CODE_RTU_DA; // RL14
            else
              err_code <= prop_code(err_src); // RL13
          end
          `DCWC_ERR_LINKPRI, `DCWC_ERR_WRIGHT, `DCWC_ERR_WRDIS: begin
            if (rtu_mode)
              err_code <= `DCWC_CODE_RTU_NK; // RL15
            else
              err_code <= prop_code(err_src); // RL13
          end
          `DCWC_ERR_FCODE: begin
            if (rtu_mode)
              err_code <= `DCWC_CODE_RTU_AD; // RL14
            else
              err_code <= prop_code(err_src); // RL13
          end
          `DCWC_ERR_BADFC: err_code <= `DCWC_CODE_RTU_FC; // RL14
          `DCWC_ERR_BADADR: err_code <= `DCWC_CODE_RTU_AD; // RL14
          default: err_code <= err_code;
        endcase
      end
      tune_cmd_pulse <= 1'b0;
      if (tune_wr && !(tune_wr_data[`DCWC_AT_FWD] && tune_wr_data[`DCWC_AT_REV])) begin // RL17
        tune_value     <= tune_wr_data[7:0]; // RL16
        tune_cmd_fwd   <= tune_wr_data[`DCWC_AT_FWD];
        tune_cmd_rev   <= tune_wr_data[`DCWC_AT_REV];
        tune_cmd_pulse <= 1'b1;
        tune_readback  <= {8'h00, tune_wr_data[7:0]}; // RL18
      end
      freq_word      <= freq_in; // RL19
      freq_sign_char <= freq_reverse ? `DCWC_ASCII_MINUS : `DCWC_ASCII_SPACE; // RL20
      // Upper byte goes out first; a new start mid-word restarts the pair
      tx_byte_valid <= 1'b0;
      if (tx_start) begin
        tx_byte       <= tx_word[15:8]; // RL21
        tx_low        <= tx_word[7:0];
        tx_byte_valid <= 1'b1;
        tx_second     <= 1'b1;
      end else if (tx_second) begin
        tx_byte       <= tx_low; // RL21
        tx_byte_valid <= 1'b1;
        tx_second     <= 1'b0;
      end
    end
  end

endmodule // dcwc_codec

// >>> hdl/dcwc_defs.vh
`ifndef DCWC_DEFS_VH
`define DCWC_DEFS_VH

// Status word bit positions
`define DCWC_ST_FWD      0
`define DCWC_ST_REV      1
`define DCWC_ST_DCB      2
`define DCWC_ST_SHUT     3
`define DCWC_ST_BRK      4
`define DCWC_ST_VOK      5
`define DCWC_ST_VLIM     7
`define DCWC_ST_ILIM     8
`define DCWC_ST_ACC      9
`define DCWC_ST_DEC      10
`define DCWC_ST_ALARM    11
`define DCWC_ST_COMM     12
`define DCWC_ST_WRITING  15

// Auto-tuning word
`define DCWC_AT_FWD      8
`define DCWC_AT_REV      9

// Error code sources
`define DCWC_ERR_NONE    4'h0
`define DCWC_ERR_CRC     4'h1
`define DCWC_ERR_PARITY  4'h2
`define DCWC_ERR_FRAME   4'h3
`define DCWC_ERR_FORMAT  4'h4
`define DCWC_ERR_CMD     4'h5
`define DCWC_ERR_LINKPRI 4'h6
`define DCWC_ERR_WRIGHT  4'h7
`define DCWC_ERR_FCODE   4'h8
`define DCWC_ERR_WRDIS   4'h9
`define DCWC_ERR_DATA    4'ha
`define DCWC_ERR_BUSY    4'hb
`define DCWC_ERR_BADFC   4'hc
`define DCWC_ERR_BADADR  4'hd

// Error codes
`define DCWC_CODE_CRC    16'h0047
`define DCWC_CODE_PARITY 16'h0048
`define DCWC_CODE_FRAME  16'h0049
`define DCWC_CODE_PROP0  16'h004a
`define DCWC_CODE_RTU_FC 16'h0001
`define DCWC_CODE_RTU_AD 16'h0002
`define DCWC_CODE_RTU_DA 16'h0003
`define DCWC_CODE_RTU_NK 16'h0007

// Current limit: 655.00 A in 0.01 A steps
`define DCWC_CUR_MAX     16'hffdc
`define DCWC_CUR_KEEP    16'h2710
`define DCWC_CUR_DIGIT   16'h000a

`define DCWC_ASCII_MINUS 8'h2d
`define DCWC_ASCII_SPACE 8'h20

`endif

// >>> test/dcwc_codec_assertions.sv
`timescale 1ns/1ps
module dcwc_codec_chk (
  input wire        clk_sys,
  input wire        rstn,
  input wire        ce,
  input wire        status_sample,
  input wire        turning_forward,
  input wire        turning_reverse,
  input wire [15:0] status_word,
  input wire        err_valid,
  input wire [3:0]  err_src,
  input wire        rtu_mode,
  input wire [15:0] err_code,
  input wire        err_no_response,
  input wire [15:0] tune_readback,
  input wire        freq_reverse,
  input wire [7:0]  freq_sign_char
);
  wire take = ce && err_valid;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_status_zeros: assert property ({status_word[14:13], status_word[6]} == 3'h0)
    else $error("zero bits set");
  chk_status_dir: assert property (ce && status_sample |=>
    status_word[1:0] == $past({turning_reverse, turning_forward})) else $error("dir bits");
  chk_status_hold: assert property (ce && !status_sample |=> $stable(status_word))
    else $error("status moved");
  chk_err_common: assert property (take && err_src inside {[1:3]} |=>
    err_code == 16'h0046 + $past(err_src) && err_no_response) else $error("common code");
  chk_err_own: assert property (take && !rtu_mode && err_src inside {[4:11]} |=>
    err_code == 16'h0046 + $past(err_src)) else $error("own code");
  chk_err_nak: assert property (take && rtu_mode && err_src inside {6, 7, 9} |=>
    err_code == 16'h0007) else $error("nak code");
  chk_tune_dirs: assert property (tune_readback[9:8] == 2'b00) else $error("tune dirs");
  chk_freq_sign: assert property (ce |=>
    freq_sign_char == ($past(freq_reverse) ? 8'h2d : 8'h20)) else $error("sign char");
  cover property (take && rtu_mode);
  cover property (take && err_src == 4'h1);
  cover property (ce && status_sample);
endmodule // dcwc_codec_chk
bind dcwc_codec dcwc_codec_chk i_dcwc_codec_chk (.*);

// >>> test/dcwc_host_model.sv
`timescale 1ns/1ps
module dcwc_host_model (
  input  wire        clk_sys,
  input  wire [7:0]  tx_byte,
  input  wire        tx_byte_valid,
  output reg  [15:0] rx_word
);
  always @(posedge clk_sys)
    if (tx_byte_valid) rx_word <= {rx_word[7:0], tx_byte};
endmodule // dcwc_host_model

// >>> test/drive_comm_word_codec_tb.sv
`timescale 1ns/1ps
module drive_comm_word_codec_tb;
  reg         clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, status_sample = 1'b0, tx_start = 1'b0;
  reg         large_drive = 1'b0, cur_wr = 1'b0, err_valid = 1'b0, rtu_mode = 1'b0;
  reg         tune_wr = 1'b0, freq_reverse = 1'b0;
  reg  [15:0] st = 16'h0000, cur_wr_data = 16'h0000, tune_wr_data = 16'h0000;
  reg  [15:0] freq_in = 16'h0000, tx_word = 16'h0000, es = 16'h0000, em = 16'h0000;
  reg  [15:0] ec = 16'h0000, et = 16'h0000;
  reg  [3:0]  err_src = 4'h0;
  reg  [31:0] seed = 32'h00016187;
  wire [15:0] status_word, model_word, cur_value, err_code, tune_readback, freq_word, rx_word;
  wire [7:0]  tune_value, freq_sign_char, tx_byte;
  wire        cur_rejected, tune_cmd_fwd, tune_cmd_rev, tx_byte_valid;
  wire        tune_cmd_pulse, err_no_response;
  integer     n_errors = 0, checked = 0, cycles = 0, i;
  dcwc_codec i_dcwc_codec (.*, .turning_forward(st[0]),
    .turning_reverse(st[1]), .dc_braking_active(st[2]), .output_shut_down(st[3]),
    .braking_active(st[4]), .dc_link_voltage_ok(st[5]), .voltage_limiting(st[7]),
    .current_limiting(st[8]), .accelerating(st[9]), .decelerating(st[10]),
    .fault_alarm_relay(st[11]), .comm_control_effective(st[12]), .fcode_writing(st[15]));
  dcwc_host_model i_dcwc_host_model (.*);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cycles <= cycles + 1;
  always @(posedge clk_sys) if (cycles > 2000) tally_and_finish;
  task chk(input [15:0] got, input [15:0] exp);
    checked = checked + 1;
    if (got !== exp) n_errors = n_errors + 1;
    if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
  endtask
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [15:0] err_exp(input [3:0] s, input r, input [15:0] o);
    err_exp = (s == 4'h0 || s > 4'hd) ? o :
              (s < 4'h4 || (!r && s < 4'hc)) ? 16'h0046 + s : 16'h0003;
    if (r && (s == 4'h6 || s == 4'h7 || s == 4'h9)) err_exp = 16'h0007;
    if (s == 4'hd || (r && s == 4'h8)) err_exp = 16'h0002;
    if (s == 4'hc) err_exp = 16'h0001;
  endfunction
  task tally_and_finish;
    if (cycles > 2000) n_errors = n_errors + 1;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    {cur_wr, err_valid, tune_wr} = 3'h7;
    for (i = 0; i < 32; i = i + 1) begin
      seed = xs(seed);
      {freq_in, st} = seed;
      {tx_word, tune_wr_data} = {i[1:0] == 2'b00 ? seed[23:8] : tx_word, 6'h00, seed[25:16]};
      cur_wr_data = (i < 3) ? 16'hffdb + i[15:0] : seed[31:16];
      {large_drive, rtu_mode, err_src, status_sample, tx_start, freq_reverse} =
        {i[4], i[4:0], i[0], i[1:0] == 2'b00, seed[6]};
      if (i[0]) es = st & 16'h9fbf;
      em = err_exp(err_src, rtu_mode, em);
      if (large_drive || cur_wr_data <= 16'hffdc)
        ec = cur_wr_data - (cur_wr_data > 16'h270f ? cur_wr_data % 16'h000a : 16'h0000);
      if (~&tune_wr_data[9:8]) et = tune_wr_data;
      @(negedge clk_sys);
      chk(status_word, es);
      chk(err_code, em);
      chk({15'h0000, err_no_response}, {15'h0000, err_src != 4'h0 && err_src < 4'h4});
      chk({15'h0000, tune_cmd_pulse}, {15'h0000, ~&tune_wr_data[9:8]});
      chk(cur_value, ec);
      chk({15'h0000, cur_rejected}, {15'h0000, !large_drive && cur_wr_data > 16'hffdc});
      chk({6'h00, tune_cmd_rev, tune_cmd_fwd, tune_value}, et);
      chk(tune_readback, et & 16'hfcff);
      chk(freq_word, freq_in);
      chk({8'h00, freq_sign_char}, freq_reverse ? 16'h002d : 16'h0020);
      if (i[1:0] == 2'b10) chk(rx_word, tx_word);
    end
    // Clock enable low must freeze the current and tuning writes and the status sample
    ce = 1'b0;
    st = ~st;
    cur_wr_data = 16'h0123;
    tune_wr_data = 16'h00aa;
    @(negedge clk_sys);
    chk(status_word, es);
    chk(cur_value, ec);
    chk({6'h00, tune_cmd_rev, tune_cmd_fwd, tune_value}, et);
    ce = 1'b1;
    chk(model_word, 16'h1111);
    $display("word codec test done");
    tally_and_finish;
  end
endmodule // drive_comm_word_codec_tb
